// ===== pkg/aer_cfg.svh
// Offsets, field positions and reset values of the error reporting registers
`ifndef AER_CFG_SVH
`define AER_CFG_SVH
`define AER_ADDR_W 12
`define AER_OFS_HDR 12'h100
`define AER_OFS_STAT 12'h104
`define AER_OFS_MASK 12'h108
`define AER_OFS_LOG0 12'h11c
`define AER_OFS_LOG1 12'h120
`define AER_OFS_LOG2 12'h124
`define AER_OFS_LOG3 12'h128
`define AER_CAP_ID 16'h0001
`define AER_CAP_VER 4'h1
`define AER_NEXT_PTR 12'h000
`define AER_ERR_IMPL 32'h001ff011
`define AER_BIT_TRAIN 0
`define AER_BIT_DLP 4
`define AER_BIT_POISON 12
`define AER_BIT_FCP 13
`define AER_BIT_CTO 14
`define AER_BIT_CABT 15
`define AER_BIT_UCPL 16
`define AER_BIT_ROVF 17
`define AER_BIT_MALF 18
`define AER_BIT_ECRC 19
`define AER_BIT_UR 20
`define AER_STAT_RST 32'h00000000
`define AER_MASK_RST 32'h00000000
`endif

// ===== pkg/aer_pkg.sv
// Types shared by the error reporting register block
`default_nettype none
package aer_pkg;
    typedef logic [31:0] aer_word_t;
    typedef logic [11:0] aer_addr_t;
    typedef struct packed {
        aer_addr_t addr;
        aer_word_t wdata;
        logic wr;
        logic rd;
    } aer_bus_s;
    typedef struct packed {
        logic valid;
        logic [127:0] header;
    } aer_tlp_s;
    typedef struct packed {
        logic valid;
        logic [4:0] bitPos;
        logic [127:0] header;
    } aer_log_s;
    typedef enum logic [0:0] {
        AER_LOG_FREE = 1'b0,
        AER_LOG_HELD = 1'b1
    } aer_logst_e;
    typedef struct packed {
        aer_word_t status;
        aer_word_t mask;
        aer_word_t rdata;
        aer_logst_e logState;
        logic [127:0] logHdr;
        logic [4:0] firstErr;
        logic msgValid;
        logic [4:0] msgBit;
    } aer_state_s;
endpackage : aer_pkg
`default_nettype wire

// ===== logic/aer_uncorr_regs.sv
// Uncorrectable error status, mask, capability header and header log
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "aer_cfg.svh"
module aer_uncorr_regs
(
    input wire logic clock,
    input wire logic nrst,
    input wire aer_pkg::aer_bus_s bus,
    input wire logic [31:0] errEvent,
    input wire aer_pkg::aer_tlp_s errTlp,
    output logic [31:0] rdata,
    output logic errMsgValid,
    output logic [4:0] errMsgBit,
    output logic [4:0] firstErrPtr
);
    import aer_pkg::*;

    aer_state_s s_q;
    aer_state_s s_d;
    logic [31:0] unmasked;
    logic [31:0] w1c;

    // Lowest set bit index, used to pick the reported error
    function automatic logic [4:0] aer_lowest(input logic [31:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 31; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction : aer_lowest

    // Header doubleword with its bytes put in big-endian order
    function automatic aer_word_t aer_swap(input aer_word_t w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : aer_swap

    always_comb
    begin
        s_d = s_q;
        s_d.msgValid = 1'b0;
        w1c = (bus.wr && bus.addr == `AER_OFS_STAT) ? bus.wdata : 32'h0;
        // Set wins over clear; masked events still flag status
        s_d.status = ((s_q.status & ~w1c) | errEvent) & `AER_ERR_IMPL;
        if (bus.wr && bus.addr == `AER_OFS_MASK)
        begin
            s_d.mask = bus.wdata & `AER_ERR_IMPL;
        end
        unmasked = errEvent & ~s_q.mask & `AER_ERR_IMPL;
        if (unmasked != 32'h0)
        begin
            s_d.msgValid = 1'b1;
            s_d.msgBit = aer_lowest(unmasked);
        end
        // Log holds until software clears the status bit it belongs to,
        // so a burst of errors cannot overwrite the first header
        case (s_q.logState)
        AER_LOG_FREE:
        begin
            if (unmasked != 32'h0)
            begin
                s_d.logState = AER_LOG_HELD;
                s_d.firstErr = aer_lowest(unmasked);
                s_d.logHdr = errTlp.valid ? errTlp.header : 128'h0;
            end
        end
        AER_LOG_HELD:
        begin
            if (!s_d.status[s_q.firstErr])
            begin
                s_d.logState = AER_LOG_FREE;
            end
        end
        default:
        begin
            s_d.logState = AER_LOG_FREE;
        end
        endcase
        s_d.rdata = 32'h0;
        if (bus.rd)
        begin
            case (bus.addr)
            `AER_OFS_HDR: s_d.rdata = {`AER_NEXT_PTR, `AER_CAP_VER, `AER_CAP_ID};
            `AER_OFS_STAT: s_d.rdata = s_q.status;
            `AER_OFS_MASK: s_d.rdata = s_q.mask;
            `AER_OFS_LOG0: s_d.rdata = aer_swap(s_q.logHdr[127:96]);
            `AER_OFS_LOG1: s_d.rdata = aer_swap(s_q.logHdr[95:64]);
            `AER_OFS_LOG2: s_d.rdata = aer_swap(s_q.logHdr[63:32]);
            `AER_OFS_LOG3: s_d.rdata = aer_swap(s_q.logHdr[31:0]);
            default: s_d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q.status <= `AER_STAT_RST;
            s_q.mask <= `AER_MASK_RST;
            s_q.rdata <= 32'h0;
            s_q.logState <= AER_LOG_FREE;
            s_q.logHdr <= 128'h0;
            s_q.firstErr <= 5'h00;
            s_q.msgValid <= 1'b0;
            s_q.msgBit <= 5'h00;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign errMsgValid = s_q.msgValid;
    assign errMsgBit = s_q.msgBit;
    assign firstErrPtr = s_q.firstErr;

    property p_hdr_read;
        @(posedge clock) disable iff (!nrst)
        bus.rd && bus.addr == `AER_OFS_HDR |=> rdata == 32'h00010001;
    endproperty
    a_hdr_read: assert property (p_hdr_read) else $error("header wrong");

    property p_ver;
        @(posedge clock) disable iff (!nrst)
        bus.rd && bus.addr == `AER_OFS_HDR |=> rdata[31:16] == 16'h0001;
    endproperty
    a_ver: assert property (p_ver) else $error("version or pointer");

    property p_set;
        @(posedge clock) disable iff (!nrst)
        errEvent[`AER_BIT_TRAIN] |=> s_q.status[`AER_BIT_TRAIN];
    endproperty
    a_set: assert property (p_set) else $error("training flag lost");

    property p_set_wins;
        @(posedge clock) disable iff (!nrst)
        errEvent[`AER_BIT_UR] && w1c[`AER_BIT_UR] |=> s_q.status[`AER_BIT_UR];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost");

    property p_sticky;
        @(posedge clock) disable iff (!nrst)
        s_q.status[`AER_BIT_DLP] && !w1c[`AER_BIT_DLP]
            |=> s_q.status[`AER_BIT_DLP];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");

    property p_clear;
        @(posedge clock) disable iff (!nrst)
        w1c[`AER_BIT_POISON] && !errEvent[`AER_BIT_POISON]
            |=> !s_q.status[`AER_BIT_POISON];
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");

    property p_masked;
        @(posedge clock) disable iff (!nrst)
        (errEvent & `AER_ERR_IMPL & ~s_q.mask) == 32'h0 |=> !errMsgValid;
    endproperty
    a_masked: assert property (p_masked) else $error("masked msg");

    property p_masked_flag;
        @(posedge clock) disable iff (!nrst)
        errEvent[`AER_BIT_ECRC] && s_q.mask[`AER_BIT_ECRC]
            |=> s_q.status[`AER_BIT_ECRC];
    endproperty
    a_masked_flag: assert property (p_masked_flag) else $error("no flag");

    property p_rsvd;
        @(posedge clock) disable iff (!nrst)
        ((s_q.status | s_q.mask) & ~`AER_ERR_IMPL) == 32'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    property p_log;
        @(posedge clock) disable iff (!nrst)
        s_q.logState == AER_LOG_FREE && errEvent[`AER_BIT_MALF]
            && !s_q.mask[`AER_BIT_MALF] && errTlp.valid
            |=> s_q.logHdr == $past(errTlp.header);
    endproperty
    a_log: assert property (p_log) else $error("header not logged");

    // Per cause: the flag always sets, and its mask keeps message and log quiet
    property p_set_dlp;
        @(posedge clock) disable iff (!nrst)
        errEvent[`AER_BIT_DLP] |=> s_q.status[`AER_BIT_DLP];
    endproperty
    a_set_dlp: assert property (p_set_dlp) else $error("dlp flag");

    property p_set_poison;
        @(posedge clock) disable iff (!nrst)
        errEvent[`AER_BIT_POISON] |=> s_q.status[`AER_BIT_POISON];
    endproperty
    a_set_poison: assert property (p_set_poison) else $error("poison");

    property p_set_fcp;
        @(posedge clock) disable iff (!nrst)
        errEvent[`AER_BIT_FCP] |=> s_q.status[`AER_BIT_FCP];
    endproperty
    a_set_fcp: assert property (p_set_fcp) else $error("fcp flag");

    property p_set_cto;
        @(posedge clock) disable iff (!nrst)
        errEvent[`AER_BIT_CTO] |=> s_q.status[`AER_BIT_CTO];
    endproperty
    a_set_cto: assert property (p_set_cto) else $error("timeout flag");

    property p_set_cabt;
        @(posedge clock) disable iff (!nrst)
        errEvent[`AER_BIT_CABT] |=> s_q.status[`AER_BIT_CABT];
    endproperty
    a_set_cabt: assert property (p_set_cabt) else $error("abort flag");

    property p_set_ucpl;
        @(posedge clock) disable iff (!nrst)
        errEvent[`AER_BIT_UCPL] |=> s_q.status[`AER_BIT_UCPL];
    endproperty
    a_set_ucpl: assert property (p_set_ucpl) else $error("ucpl flag");

    property p_set_rovf;
        @(posedge clock) disable iff (!nrst)
        errEvent[`AER_BIT_ROVF] |=> s_q.status[`AER_BIT_ROVF];
    endproperty
    a_set_rovf: assert property (p_set_rovf) else $error("ovf flag");

    property p_set_malf;
        @(posedge clock) disable iff (!nrst)
        errEvent[`AER_BIT_MALF] |=> s_q.status[`AER_BIT_MALF];
    endproperty
    a_set_malf: assert property (p_set_malf) else $error("malf flag");

    property p_set_ecrc;
        @(posedge clock) disable iff (!nrst)
        errEvent[`AER_BIT_ECRC] |=> s_q.status[`AER_BIT_ECRC];
    endproperty
    a_set_ecrc: assert property (p_set_ecrc) else $error("crc flag");

    property p_set_ur;
        @(posedge clock) disable iff (!nrst)
        errEvent[`AER_BIT_UR] |=> s_q.status[`AER_BIT_UR];
    endproperty
    a_set_ur: assert property (p_set_ur) else $error("ur flag");

    property p_quiet_train;
        @(posedge clock) disable iff (!nrst)
        errEvent == (32'h1 << `AER_BIT_TRAIN) && s_q.mask[`AER_BIT_TRAIN]
            |=> !errMsgValid && $stable(s_q.logHdr);
    endproperty
    a_quiet_train: assert property (p_quiet_train) else $error("q0");

    property p_quiet_dlp;
        @(posedge clock) disable iff (!nrst)
        errEvent == (32'h1 << `AER_BIT_DLP) && s_q.mask[`AER_BIT_DLP]
            |=> !errMsgValid && $stable(s_q.logHdr);
    endproperty
    a_quiet_dlp: assert property (p_quiet_dlp) else $error("q4");

    property p_quiet_poison;
        @(posedge clock) disable iff (!nrst)
        errEvent == (32'h1 << `AER_BIT_POISON) && s_q.mask[`AER_BIT_POISON]
            |=> !errMsgValid && $stable(s_q.logHdr);
    endproperty
    a_quiet_poison: assert property (p_quiet_poison) else $error("q12");

    property p_quiet_fcp;
        @(posedge clock) disable iff (!nrst)
        errEvent == (32'h1 << `AER_BIT_FCP) && s_q.mask[`AER_BIT_FCP]
            |=> !errMsgValid && $stable(s_q.logHdr);
    endproperty
    a_quiet_fcp: assert property (p_quiet_fcp) else $error("q13");

    property p_quiet_cto;
        @(posedge clock) disable iff (!nrst)
        errEvent == (32'h1 << `AER_BIT_CTO) && s_q.mask[`AER_BIT_CTO]
            |=> !errMsgValid && $stable(s_q.logHdr);
    endproperty
    a_quiet_cto: assert property (p_quiet_cto) else $error("q14");

    property p_quiet_cabt;
        @(posedge clock) disable iff (!nrst)
        errEvent == (32'h1 << `AER_BIT_CABT) && s_q.mask[`AER_BIT_CABT]
            |=> !errMsgValid && $stable(s_q.logHdr);
    endproperty
    a_quiet_cabt: assert property (p_quiet_cabt) else $error("q15");

    property p_quiet_ucpl;
        @(posedge clock) disable iff (!nrst)
        errEvent == (32'h1 << `AER_BIT_UCPL) && s_q.mask[`AER_BIT_UCPL]
            |=> !errMsgValid && $stable(s_q.logHdr);
    endproperty
    a_quiet_ucpl: assert property (p_quiet_ucpl) else $error("q16");

    property p_quiet_rovf;
        @(posedge clock) disable iff (!nrst)
        errEvent == (32'h1 << `AER_BIT_ROVF) && s_q.mask[`AER_BIT_ROVF]
            |=> !errMsgValid && $stable(s_q.logHdr);
    endproperty
    a_quiet_rovf: assert property (p_quiet_rovf) else $error("q17");

    property p_quiet_malf;
        @(posedge clock) disable iff (!nrst)
        errEvent == (32'h1 << `AER_BIT_MALF) && s_q.mask[`AER_BIT_MALF]
            |=> !errMsgValid && $stable(s_q.logHdr);
    endproperty
    a_quiet_malf: assert property (p_quiet_malf) else $error("q18");

    property p_quiet_ecrc;
        @(posedge clock) disable iff (!nrst)
        errEvent == (32'h1 << `AER_BIT_ECRC) && s_q.mask[`AER_BIT_ECRC]
            |=> !errMsgValid && $stable(s_q.logHdr);
    endproperty
    a_quiet_ecrc: assert property (p_quiet_ecrc) else $error("q19");

    property p_quiet_ur;
        @(posedge clock) disable iff (!nrst)
        errEvent == (32'h1 << `AER_BIT_UR) && s_q.mask[`AER_BIT_UR]
            |=> !errMsgValid && $stable(s_q.logHdr);
    endproperty
    a_quiet_ur: assert property (p_quiet_ur) else $error("q20");

    property p_msg_raise;
        @(posedge clock) disable iff (!nrst)
        (errEvent & ~s_q.mask & `AER_ERR_IMPL) != 32'h0 |=> errMsgValid;
    endproperty
    a_msg_raise: assert property (p_msg_raise) else $error("no message");

    property p_msg_bit;
        @(posedge clock) disable iff (!nrst)
        errEvent == (32'h1 << `AER_BIT_UR) && !s_q.mask[`AER_BIT_UR]
            |=> errMsgBit == 5'h14;
    endproperty
    a_msg_bit: assert property (p_msg_bit) else $error("message bit");

    property p_stat_rsvd;
        @(posedge clock) disable iff (!nrst)
        bus.rd && bus.addr == `AER_OFS_STAT
            |=> (rdata & ~`AER_ERR_IMPL) == 32'h0;
    endproperty
    a_stat_rsvd: assert property (p_stat_rsvd) else $error("status rsvd");

    property p_mask_rsvd;
        @(posedge clock) disable iff (!nrst)
        bus.rd && bus.addr == `AER_OFS_MASK
            |=> (rdata & ~`AER_ERR_IMPL) == 32'h0;
    endproperty
    a_mask_rsvd: assert property (p_mask_rsvd) else $error("mask rsvd");

    property p_mask_wr;
        @(posedge clock) disable iff (!nrst)
        bus.wr && bus.addr == `AER_OFS_MASK
            |=> s_q.mask == ($past(bus.wdata) & `AER_ERR_IMPL);
    endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask write");

    // A held log must not be overwritten by later errors
    property p_log_hold;
        @(posedge clock) disable iff (!nrst)
        s_q.logState == AER_LOG_HELD |=> $stable(s_q.logHdr);
    endproperty
    a_log_hold: assert property (p_log_hold) else $error("log overrun");
endmodule : aer_uncorr_regs
`default_nettype wire

// ===== dv/aer_rc_model.sv
// Root complex model issuing configuration reads and writes
`timescale 1ns/100ps
`default_nettype none
module aer_rc_model
(
    input wire logic clock,
    input wire logic [31:0] rdata,
    output var aer_pkg::aer_bus_s bus
);
    import aer_pkg::*;
    initial bus = '0;
    task automatic wr(input aer_addr_t a, input aer_word_t d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        // Idle bus shows inverted values so stale ones are never trusted
        bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : wr
    task automatic rd(input aer_addr_t a, output aer_word_t d);
        @(posedge clock);
        bus <= '{addr: a, wdata: 32'h5a5a5a5a, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus <= '{addr: ~a, wdata: 32'ha5a5a5a5, wr: 1'b0, rd: 1'b0};
        #1;
        d = rdata;
    endtask : rd
endmodule : aer_rc_model
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the error reporting register block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import aer_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    aer_bus_s bus;
    logic [31:0] errEvent = '0;
    aer_tlp_s errTlp = '0;
    logic [31:0] rdata;
    logic errMsgValid;
    logic [4:0] errMsgBit;
    logic [4:0] firstErrPtr;
    int err_count = 0;
    int checks_done = 0;
    int bits[11] = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20};
    always #20 clock = ~clock;
    aer_uncorr_regs u_aer_uncorr_regs (.clock(clock), .nrst(nrst),
        .bus(bus), .errEvent(errEvent), .errTlp(errTlp), .rdata(rdata),
        .errMsgValid(errMsgValid), .errMsgBit(errMsgBit),
        .firstErrPtr(firstErrPtr));
    aer_rc_model u_aer_rc_model (.clock(clock), .rdata(rdata), .bus(bus));
    task automatic chk(input string n, input aer_word_t s, input aer_word_t e);
        checks_done++;
        if (s !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic close_out;
        if (err_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    function automatic aer_word_t swap(input aer_word_t w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : swap
    task automatic rc(input string n, input aer_addr_t a, input aer_word_t e);
        aer_word_t d;
        u_aer_rc_model.rd(a, d);
        chk(n, d, e);
        @(posedge clock);
        #1;
        chk("rdataIdle", rdata, '0);
    endtask : rc
    task automatic pulse(input int b, input logic [127:0] h, input logic m);
        @(posedge clock);
        errEvent <= 32'h1 << b;
        errTlp <= '{valid: 1'b1, header: h};
        @(posedge clock);
        errEvent <= '0;
        errTlp.valid <= 1'b0;
        #1;
        chk("msgValid", {31'h0, errMsgValid}, {31'h0, m});
        @(posedge clock);
        #1;
        chk("msgDrop", {31'h0, errMsgValid}, '0);
    endtask : pulse
    // Event and write-one-clear land on the same edge: the set must win
    task automatic t_collide;
        fork
            u_aer_rc_model.wr(12'h104, 32'h00100000);
            begin
                @(posedge clock);
                errEvent <= 32'h00100000;
                @(posedge clock);
                errEvent <= '0;
            end
        join
        rc("setWins", 12'h104, 32'h00100000);
        u_aer_rc_model.wr(12'h104, 32'h00100000);
        rc("clearOnce", 12'h104, '0);
    endtask : t_collide
    task automatic t_reset;
        rc("header", 12'h100, 32'h00010001);
        rc("status", 12'h104, '0);
        rc("mask", 12'h108, '0);
        u_aer_rc_model.wr(12'h100, 32'hffffffff);
        rc("headerRo", 12'h100, 32'h00010001);
        rc("unmapped", 12'h10c, '0);
        pulse(1, '0, 1'b0);
        rc("rsvdStat", 12'h104, '0);
    endtask : t_reset
    task automatic t_events;
        logic [127:0] h;
        aer_word_t m;
        foreach (bits[i])
        begin
            m = 32'h1 << bits[i];
            h = {32'h11223344 + i, 32'h55667788, 32'h99aabbcc, 32'hddeeff00};
            pulse(bits[i], h, 1'b1);
            chk("msgBit", {27'h0, errMsgBit}, 32'(bits[i]));
            chk("firstErr", {27'h0, firstErrPtr}, 32'(bits[i]));
            for (int k = 0; k < 4; k++)
                rc("log", 12'h11c + 12'(4 * k), swap(h[127 - 32 * k -: 32]));
            u_aer_rc_model.wr(12'h104, ~m);
            rc("sticky", 12'h104, m);
            u_aer_rc_model.wr(12'h104, m);
            rc("cleared", 12'h104, '0);
        end
    endtask : t_events
    task automatic t_masked;
        u_aer_rc_model.wr(12'h108, 32'hffffffff);
        rc("maskRw", 12'h108, 32'h001ff011);
        foreach (bits[i])
            pulse(bits[i], '1, 1'b0);
        rc("maskedStat", 12'h104, 32'h001ff011);
        chk("noLogPtr", {27'h0, firstErrPtr}, 32'd20);
        rc("noLog", 12'h11c, swap(32'h11223344 + 10));
        u_aer_rc_model.wr(12'h104, 32'hffffffff);
        rc("allClear", 12'h104, '0);
    endtask : t_masked
    initial
    begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_events();
        t_masked();
        t_collide();
        close_out();
    end
    // Guard against a hang in any task
    initial
    begin
        #2000000;
        err_count++;
        close_out();
    end
endmodule : testbench
`default_nettype wire
